// *** verilog/pba_pkg.sv ***
// Shared constants and types for the three-slot parallel bus arbiter and its slot masters.
// Assumes one common clock for the arbiter and every slot master.

package pba_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int          NUM_MASTERS = 3;
    localparam int          AD_WIDTH    = 32;
    localparam int          COUNT_W     = 4;
    localparam logic [31:0] ADDR_STEP   = 32'h0000_0004;

    // Slot index type, one code per request/grant pair.
    typedef logic [1:0] pba_slot_t;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int BUS_CLK_HZ       = 33_000_000;
    localparam int SYS_CLK_HZ       = 10_000_000;
    localparam int CYCLES_PER_PHASE = 1;

    // ------------------------------------------------------------------
    // Configuration address word layout
    // ------------------------------------------------------------------
    localparam int        CFG_ENABLE_BIT = 31;
    localparam int        CFG_BUS_LSB    = 16;
    localparam int        CFG_DEV_LSB    = 11;
    localparam int        CFG_FN_LSB     = 8;
    localparam int        CFG_REG_LSB    = 2;
    localparam logic [1:0] CFG_TYPE0     = 2'h0;
    localparam logic [1:0] CFG_TYPE1     = 2'h1;
    localparam logic [7:0] SLOT_BUS      = 8'h07;

    // Device numbers and select lines of slots 0, 1 and 2.
    localparam logic [4:0] SLOT_DEV [NUM_MASTERS]        = '{5'h04, 5'h0B, 5'h0A};
    localparam int         SLOT_IDSEL_LINE [NUM_MASTERS] = '{20, 25, 27};

    // ------------------------------------------------------------------
    // State machines
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ARB_IDLE   = 2'b00,
        ARB_GRANT  = 2'b01,
        ARB_SWITCH = 2'b10
    } pba_arb_state_t;

    typedef enum logic [2:0] {
        MST_IDLE = 3'b000,
        MST_REQ  = 3'b001,
        MST_ADDR = 3'b010,
        MST_DATA = 3'b011,
        MST_DONE = 3'b100
    } pba_mst_state_t;

endpackage

// *** verilog/pba_if.sv ***
// Shared parallel bus joining the arbiter to three slot masters.
// Assumes each slot master drives only its own element of the per-master arrays.

`timescale 1ns/1ns

interface pba_if;
    import pba_pkg::*;

    // Request and grant pairs, active low.
    logic [NUM_MASTERS-1:0] req_n;
    logic [NUM_MASTERS-1:0] gnt_n;

    // Per-master drive of the shared lines.
    logic [NUM_MASTERS-1:0] m_frame_n;
    logic [NUM_MASTERS-1:0] m_frame_oe;
    logic [NUM_MASTERS-1:0] m_irdy_n;
    logic [NUM_MASTERS-1:0] m_irdy_oe;
    logic [AD_WIDTH-1:0]    m_ad    [NUM_MASTERS];
    logic [NUM_MASTERS-1:0] m_ad_oe;

    // Resolved wire levels; undriven control lines sit at their pulled-up level.
    logic                frame_n;
    logic                irdy_n;
    logic [AD_WIDTH-1:0] ad;

    assign frame_n = &(m_frame_n | ~m_frame_oe);
    assign irdy_n  = &(m_irdy_n | ~m_irdy_oe);
    assign ad      = (m_ad[0] & {AD_WIDTH{m_ad_oe[0]}})
                   | (m_ad[1] & {AD_WIDTH{m_ad_oe[1]}})
                   | (m_ad[2] & {AD_WIDTH{m_ad_oe[2]}});

    modport arbiter (
        input  req_n,
        input  frame_n,
        input  irdy_n,
        input  ad,
        output gnt_n
    );

    modport master (
        input  gnt_n,
        input  frame_n,
        input  irdy_n,
        input  ad,
        output req_n,
        output m_frame_n,
        output m_frame_oe,
        output m_irdy_n,
        output m_irdy_oe,
        output m_ad,
        output m_ad_oe
    );
endinterface

// *** verilog/pba_slot_master.sv ***
// Slot master end: requests the bus unless already granted on an idle bus, frames one write burst and releases the bus.
// Assumes the arbiter on the same clock and a user that holds wr_data ready ahead of data_take.

`timescale 1ns/1ns

module pba_slot_master
    import pba_pkg::*;
#(
    parameter int SLOT = 0
) (
    // Clock and reset.
    input  wire logic                sys_clk,
    input  wire logic                rst,
    // Bus side.
    pba_if.master                    bus,
    // User side.
    input  wire logic                start,
    input  wire logic [AD_WIDTH-1:0] start_addr,
    input  wire logic [COUNT_W-1:0]  word_count,
    input  wire logic [AD_WIDTH-1:0] wr_data,
    output logic                     data_take,
    output logic                     busy,
    output logic                     done,
    output logic [AD_WIDTH-1:0]      cur_addr
);
    import pba_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    pba_mst_state_t      state_reg, state_next;
    logic                req_n_reg, req_n_next;
    logic                frame_n_reg, frame_n_next, frame_oe_reg, frame_oe_next;
    logic                irdy_n_reg, irdy_n_next, irdy_oe_reg, irdy_oe_next;
    logic [AD_WIDTH-1:0] ad_reg, ad_next;
    logic                ad_oe_reg, ad_oe_next;
    logic [AD_WIDTH-1:0] addr_reg, addr_next;
    logic [COUNT_W-1:0]  left_reg, left_next;
    logic                take_reg, take_next, done_reg, done_next;
    logic                busy_reg, busy_next;
    logic                granted, bus_idle;

    assign granted  = ~bus.gnt_n[SLOT];
    assign bus_idle = bus.frame_n & bus.irdy_n;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // A zero word count is run as one data cycle, since a burst always has one.
    always_comb begin
        state_next    = state_reg;
        req_n_next    = req_n_reg;
        frame_n_next  = frame_n_reg;
        frame_oe_next = frame_oe_reg;
        irdy_n_next   = irdy_n_reg;
        irdy_oe_next  = irdy_oe_reg;
        ad_next       = ad_reg;
        ad_oe_next    = ad_oe_reg;
        addr_next     = addr_reg;
        left_next     = left_reg;
        take_next     = 1'b0;
        done_next     = 1'b0;
        case (state_reg)
            MST_IDLE: begin
                irdy_oe_next = 1'b0;
                if (start) begin
                    addr_next = start_addr;
                    left_next = (word_count == '0) ? COUNT_W'(1) : word_count;
                    if (granted && bus_idle) begin
                        state_next    = MST_ADDR;
                        frame_n_next  = 1'b0;
                        frame_oe_next = 1'b1;
                        irdy_oe_next  = 1'b1;
                        irdy_n_next   = 1'b1;
                        ad_next       = start_addr;
                        ad_oe_next    = 1'b1;
                    end else begin
                        state_next = MST_REQ;
                        req_n_next = 1'b0;
                    end
                end
            end
            MST_REQ: begin
                if (granted && bus_idle) begin
                    state_next    = MST_ADDR;
                    req_n_next    = 1'b1;
                    frame_n_next  = 1'b0;
                    frame_oe_next = 1'b1;
                    irdy_oe_next  = 1'b1;
                    irdy_n_next   = 1'b1;
                    ad_next       = addr_reg;
                    ad_oe_next    = 1'b1;
                end
            end
            MST_ADDR: begin
                state_next   = MST_DATA;
                irdy_n_next  = 1'b0;
                ad_next      = wr_data;
                take_next    = 1'b1;
                left_next    = left_reg - COUNT_W'(1);
                frame_n_next = (left_reg == COUNT_W'(1));
            end
            MST_DATA: begin
                if (left_reg == '0) begin
                    state_next    = MST_DONE;
                    irdy_n_next   = 1'b1;
                    frame_oe_next = 1'b0;
                    ad_oe_next    = 1'b0;
                    done_next     = 1'b1;
                end else begin
                    addr_next    = addr_reg + ADDR_STEP;
                    ad_next      = wr_data;
                    take_next    = 1'b1;
                    left_next    = left_reg - COUNT_W'(1);
                    frame_n_next = (left_reg == COUNT_W'(1));
                end
            end
            MST_DONE: begin
                state_next   = MST_IDLE;
                irdy_oe_next = 1'b0;
            end
            default: begin
                state_next = MST_IDLE;
            end
        endcase
        // Registered so that busy comes straight from a flip-flop.
        busy_next = (state_next != MST_IDLE);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg    <= MST_IDLE;
            req_n_reg    <= 1'b1;
            frame_n_reg  <= 1'b1;
            frame_oe_reg <= 1'b0;
            irdy_n_reg   <= 1'b1;
            irdy_oe_reg  <= 1'b0;
            ad_reg       <= '0;
            ad_oe_reg    <= 1'b0;
            addr_reg     <= '0;
            left_reg     <= '0;
            take_reg     <= 1'b0;
            done_reg     <= 1'b0;
            busy_reg     <= 1'b0;
        end else begin
            state_reg    <= state_next;
            req_n_reg    <= req_n_next;
            frame_n_reg  <= frame_n_next;
            frame_oe_reg <= frame_oe_next;
            irdy_n_reg   <= irdy_n_next;
            irdy_oe_reg  <= irdy_oe_next;
            ad_reg       <= ad_next;
            ad_oe_reg    <= ad_oe_next;
            addr_reg     <= addr_next;
            left_reg     <= left_next;
            take_reg     <= take_next;
            done_reg     <= done_next;
            busy_reg     <= busy_next;
        end
    end

    // Drive this slot's elements of the bus and the user outputs.
    assign bus.req_n[SLOT]      = req_n_reg;
    assign bus.m_frame_n[SLOT]  = frame_n_reg;
    assign bus.m_frame_oe[SLOT] = frame_oe_reg;
    assign bus.m_irdy_n[SLOT]   = irdy_n_reg;
    assign bus.m_irdy_oe[SLOT]  = irdy_oe_reg;
    assign bus.m_ad[SLOT]       = ad_reg;
    assign bus.m_ad_oe[SLOT]    = ad_oe_reg;
    assign data_take            = take_reg;
    assign done                 = done_reg;
    assign busy                 = busy_reg;
    assign cur_addr             = addr_reg;

endmodule

// *** verilog/pba_arbiter.sv ***
// Central arbiter of the three-slot parallel bus, with configuration select decode.
// Assumes slot masters on the same clock that honour the grant and frame every transaction.

`timescale 1ns/1ns

module pba_arbiter
    import pba_pkg::*;
(
    // Clock and reset.
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // Bus side.
    pba_if.arbiter                      bus,
    // Configuration address from the host side.
    input  wire logic                   cfg_valid,
    input  wire logic [AD_WIDTH-1:0]    cfg_addr,
    // Configuration address phase word and its qualifiers.
    output logic [AD_WIDTH-1:0]         cfg_ad_word,
    output logic                        cfg_issue,
    output logic                        cfg_slot_hit,
    // Per-slot configuration select, sampled in each address cycle.
    output logic [NUM_MASTERS-1:0]      slot_idsel,
    // Arbitration status.
    output logic [1:0]                  bus_owner,
    output logic                        owner_valid
);
    import pba_pkg::*;

    // ------------------------------------------------------------------
    // Arbitration state
    // ------------------------------------------------------------------
    pba_arb_state_t         state_reg, state_next;
    pba_slot_t              last_reg, last_next;
    logic                   has_owner_reg, has_owner_next;
    logic [NUM_MASTERS-1:0] gnt_n_reg, gnt_n_next;
    logic [NUM_MASTERS-1:0] req_act;
    logic                   bus_idle;
    logic                   pick_valid;
    pba_slot_t              pick;
    int                     idx;

    // Requests come from logic on this clock, so they need no synchroniser.
    assign req_act  = ~bus.req_n;
    assign bus_idle = bus.frame_n & bus.irdy_n;

    // ------------------------------------------------------------------
    // Round-robin pick
    // ------------------------------------------------------------------
    // The search starts one past the last owner, so the owner is visited last.
    // That keeps any waiting slot no more than two grants away from service.
    always_comb begin
        idx        = 0;
        pick_valid = 1'b0;
        pick       = last_reg;
        for (int k = 1; k <= NUM_MASTERS; k++) begin
            idx = (int'(last_reg) + k) % NUM_MASTERS;
            if (!pick_valid && req_act[idx]) begin
                pick_valid = 1'b1;
                pick       = pba_slot_t'(idx);
            end
        end
    end

    // ------------------------------------------------------------------
    // Grant sequencing
    // ------------------------------------------------------------------
    // A change of owner always passes through a cycle with every grant off.
    // The cost is one cycle per hand-over, more while the bus is busy; the gain is that two grants can
    // never overlap, even when the old owner starts a frame in that cycle.
    always_comb begin
        state_next     = state_reg;
        last_next      = last_reg;
        has_owner_next = has_owner_reg;
        gnt_n_next     = gnt_n_reg;
        case (state_reg)
            ARB_IDLE: begin
                gnt_n_next = '1;
                if (pick_valid && bus_idle) begin
                    state_next     = ARB_GRANT;
                    last_next      = pick;
                    has_owner_next = 1'b1;
                    gnt_n_next     = ~(NUM_MASTERS'(1) << pick);
                end
            end
            ARB_GRANT: begin
                if (pick_valid && (pick != last_reg)) begin
                    state_next = ARB_SWITCH;
                    gnt_n_next = '1;
                end else begin
                    gnt_n_next = ~(NUM_MASTERS'(1) << last_reg);
                end
            end
            ARB_SWITCH: begin
                gnt_n_next = '1;
                if (bus_idle) begin
                    state_next = ARB_GRANT;
                    if (pick_valid) begin
                        last_next  = pick;
                        gnt_n_next = ~(NUM_MASTERS'(1) << pick);
                    end else begin
                        gnt_n_next = ~(NUM_MASTERS'(1) << last_reg);
                    end
                end
            end
            default: begin
                state_next = ARB_IDLE;
                gnt_n_next = '1;
            end
        endcase
    end

    // One register step per bus clock period; sys_clk stands for the bus clock.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg     <= ARB_IDLE;
            last_reg      <= '0;
            has_owner_reg <= 1'b0;
            gnt_n_reg     <= '1;
        end else begin
            state_reg     <= state_next;
            last_reg      <= last_next;
            has_owner_reg <= has_owner_next;
            gnt_n_reg     <= gnt_n_next;
        end
    end

    assign bus.gnt_n   = gnt_n_reg;
    assign bus_owner   = last_reg;
    assign owner_valid = has_owner_reg;

    // ------------------------------------------------------------------
    // Address cycle detection and slot selects
    // ------------------------------------------------------------------
    // The first cycle with frame low after an idle cycle is the address cycle;
    // every later cycle of that frame carries data only.
    logic                   frame_prev_reg, frame_prev_next;
    logic [NUM_MASTERS-1:0] idsel_reg, idsel_next;
    logic                   addr_cycle;

    assign addr_cycle = frame_prev_reg & ~bus.frame_n;

    genvar g;
    generate
        for (g = 0; g < NUM_MASTERS; g++) begin : g_idsel
            // Each slot select is wired to its own address line.
            always_comb begin
                idsel_next[g] = addr_cycle & bus.ad[SLOT_IDSEL_LINE[g]];
            end
        end
    endgenerate

    always_comb begin
        frame_prev_next = bus.frame_n;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            frame_prev_reg <= 1'b1;
            idsel_reg      <= '0;
        end else begin
            frame_prev_reg <= frame_prev_next;
            idsel_reg      <= idsel_next;
        end
    end

    assign slot_idsel = idsel_reg;

    // ------------------------------------------------------------------
    // Configuration address translation
    // ------------------------------------------------------------------
    // Every bus 7 word becomes a type 0 cycle, with one select line set only for a
    // slot's device number; any other bus is passed on as a type 1 cycle. A word with
    // the enable bit clear starts no configuration cycle at all.
    logic [AD_WIDTH-1:0] cfg_word_reg, cfg_word_next;
    logic                cfg_issue_reg, cfg_issue_next;
    logic                cfg_hit_reg, cfg_hit_next;
    logic [7:0]          cfg_bus;
    logic [4:0]          cfg_dev;

    assign cfg_bus = cfg_addr[CFG_BUS_LSB +: 8];
    assign cfg_dev = cfg_addr[CFG_DEV_LSB +: 5];

    always_comb begin
        cfg_word_next  = cfg_word_reg;
        cfg_issue_next = 1'b0;
        cfg_hit_next   = cfg_hit_reg;
        if (cfg_valid && cfg_addr[CFG_ENABLE_BIT]) begin
            cfg_issue_next = 1'b1;
            cfg_hit_next   = 1'b0;
            if (cfg_bus == SLOT_BUS) begin
                cfg_word_next = {21'h000000, cfg_addr[CFG_FN_LSB +: 3],
                                 cfg_addr[CFG_REG_LSB +: 6], CFG_TYPE0};
                for (int s = 0; s < NUM_MASTERS; s++) begin
                    if (cfg_dev == SLOT_DEV[s]) begin
                        cfg_word_next[SLOT_IDSEL_LINE[s]] = 1'b1;
                        cfg_hit_next                      = 1'b1;
                    end
                end
            end else begin
                cfg_word_next = {8'h00, cfg_addr[23:2], CFG_TYPE1};
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_word_reg  <= '0;
            cfg_issue_reg <= 1'b0;
            cfg_hit_reg   <= 1'b0;
        end else begin
            cfg_word_reg  <= cfg_word_next;
            cfg_issue_reg <= cfg_issue_next;
            cfg_hit_reg   <= cfg_hit_next;
        end
    end

    assign cfg_ad_word  = cfg_word_reg;
    assign cfg_issue    = cfg_issue_reg;
    assign cfg_slot_hit = cfg_hit_reg;

endmodule

// *** sim/pba_sva.sv ***
// Concurrent checks on the shared bus between the arbiter and the three slot masters.
// Assumes the testbench top wires the interface lines in by name.
`timescale 1ns/1ns
module pba_sva (
    // Clock and reset.
    input wire logic                            sys_clk,
    input wire logic                            rst,
    // Bus lines.
    input wire logic [pba_pkg::NUM_MASTERS-1:0] req_n,
    input wire logic [pba_pkg::NUM_MASTERS-1:0] gnt_n,
    input wire logic                            frame_n,
    input wire logic                            irdy_n
);
    import pba_pkg::*;
    // -------------------------
    // Arbitration and framing
    // -------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_one_grant: assert property ($onehot0(~gnt_n))
        else $error("more than one grant active");
    a_grant_requester: assert property ((($past(gnt_n) & ~gnt_n) != 3'h0) |->
        (($past(gnt_n) & ~gnt_n & $past(req_n)) == 3'h0)) else $error("grant without request");
    a_grant_idle_bus: assert property ((($past(gnt_n) & ~gnt_n) != 3'h0) |-> $past(frame_n && irdy_n))
        else $error("grant issued on busy bus");
    a_park_hold: assert property (&req_n |=> $stable(gnt_n))
        else $error("parked grant moved");
    a_switch_off: assert property ((gnt_n != 3'h7) && ((~req_n & gnt_n) != 3'h0) |=> gnt_n == 3'h7)
        else $error("grant kept while another requests");
    a_frame_granted: assert property ($fell(frame_n) |-> $past(gnt_n) != 3'h7)
        else $error("frame without grant");
    a_addr_then_data: assert property ($fell(frame_n) |=> !irdy_n)
        else $error("no data cycle after address");
    a_data_stays: assert property (!frame_n && !irdy_n |=> !irdy_n)
        else $error("gap in burst");
    a_last_data_end: assert property ($rose(frame_n) && !irdy_n |=> irdy_n)
        else $error("burst ran past last data");

    // Main scenarios: grant to slot 2, hand-over, long burst.
    cover property ($fell(gnt_n[2]));
    cover property (gnt_n != 3'h7 ##1 gnt_n == 3'h7);
    cover property ($fell(frame_n) ##1 !irdy_n [*8]);
endmodule

// *** sim/testbench.sv ***
// Self-checking bench joining the arbiter to three slot masters over one interface.
// Assumes the package and interface of the design are compiled first.
`timescale 1ns/1ns
module testbench;
    import pba_pkg::*;
    logic                   sys_clk;
    logic                   rst;
    logic                   start      [NUM_MASTERS];
    logic [AD_WIDTH-1:0]    start_addr [NUM_MASTERS];
    logic [COUNT_W-1:0]     word_count [NUM_MASTERS];
    logic [AD_WIDTH-1:0]    wr_data    [NUM_MASTERS];
    logic [NUM_MASTERS-1:0] data_take, busy, done, slot_idsel, req_seen, done_seen;
    logic [AD_WIDTH-1:0]    cur_addr   [NUM_MASTERS];
    logic                   cfg_valid, cfg_issue, cfg_slot_hit, owner_valid, prev_frame, addr_seen;
    logic [AD_WIDTH-1:0]    cfg_addr, cfg_ad_word, last_addr, cur;
    logic [1:0]             bus_owner;
    logic [31:0]            own_q[$], addr_q[$], cnt_q[$];
    int                     widx [NUM_MASTERS];
    int                     n_mismatch, checks, k, nb;

    pba_if pba_if_i();
    pba_arbiter pba_arbiter_i (.sys_clk, .rst, .bus(pba_if_i.arbiter), .cfg_valid, .cfg_addr, .cfg_ad_word,
        .cfg_issue, .cfg_slot_hit, .slot_idsel, .bus_owner, .owner_valid);
    pba_sva pba_sva_i (.sys_clk, .rst, .req_n(pba_if_i.req_n), .gnt_n(pba_if_i.gnt_n), .frame_n(pba_if_i.frame_n),
        .irdy_n(pba_if_i.irdy_n));

    function automatic logic [31:0] pat(int s, int n);
        return 32'hA500_0000 | (s << 8) | n;
    endfunction

    // Masters; the next word is put up at the address cycle's end and at each take, one edge ahead of its capture.
    for (genvar s = 0; s < NUM_MASTERS; s++) begin : g_slot
        pba_slot_master #(.SLOT(s)) pba_slot_master_i (.sys_clk, .rst, .bus(pba_if_i.master), .start(start[s]),
            .start_addr(start_addr[s]), .word_count(word_count[s]), .wr_data(wr_data[s]),
            .data_take(data_take[s]), .busy(busy[s]), .done(done[s]), .cur_addr(cur_addr[s]));
        always @(posedge sys_clk) begin
            if (data_take[s] || (pba_if_i.m_frame_oe[s] && !pba_if_i.m_frame_n[s] && pba_if_i.m_irdy_n[s])) begin
                widx[s] = widx[s] + 1;
                wr_data[s] <= pat(s, widx[s]);
            end
        end
    end

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic compare(logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Wire monitor: logs each address cycle, checks every data word and the select pulse after it.
    always @(posedge sys_clk) begin
        req_seen = req_seen | ~pba_if_i.req_n;
        done_seen = done_seen | done;
        if (addr_seen) compare({29'h0, slot_idsel}, {29'h0, last_addr[27], last_addr[25], last_addr[20]});
        addr_seen = 1'b0;
        if (!pba_if_i.frame_n && prev_frame) begin
            cur = pba_if_i.m_frame_oe[2] ? 32'd2 : {31'h0, pba_if_i.m_frame_oe[1]};
            last_addr = pba_if_i.ad;
            own_q.push_back(cur);
            addr_q.push_back(last_addr);
            cnt_q.push_back(32'd0);
            k = 0;
            addr_seen = 1'b1;
        end else if (!pba_if_i.irdy_n) begin
            compare(pba_if_i.ad, pat(cur, k));
            k++;
            cnt_q[cnt_q.size()-1] = k;
        end
        prev_frame = pba_if_i.frame_n;
    end

    task automatic launch(int s, logic [31:0] a, logic [3:0] n);
        widx[s] = 0;
        wr_data[s] <= pat(s, 0);
        start_addr[s] <= a;
        word_count[s] <= n;
        start[s] <= 1'b1;
    endtask

    // Releases the starts and waits, bounded, until every master is idle again.
    task automatic go();
        int i;
        nb = own_q.size();
        done_seen = '0;
        @(posedge sys_clk);
        for (i = 0; i < NUM_MASTERS; i++) start[i] <= 1'b0;
        repeat (2) @(posedge sys_clk);
        for (i = 0; i < 300 && busy !== 3'h0; i++) @(posedge sys_clk);
        if (i == 300) begin
            n_mismatch++;
            complete_run();
        end
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic burst(int i, logic [31:0] o, logic [31:0] a, logic [31:0] n);
        compare(own_q[nb+i], o);
        compare(addr_q[nb+i], a);
        compare(cnt_q[nb+i], n);
    endtask

    task automatic cfg(logic [7:0] b, logic [4:0] d, logic en, logic [31:0] w, logic h);
        @(posedge sys_clk);
        cfg_valid <= 1'b1;
        cfg_addr <= {en, 7'h00, b, d, 3'h5, 6'h0A, 2'b00};
        @(posedge sys_clk);
        cfg_valid <= 1'b0;
        @(posedge sys_clk);
        compare({31'h0, cfg_issue}, {31'h0, en});
        if (en) compare(cfg_ad_word, w);
        if (en) compare({31'h0, cfg_slot_hit}, {31'h0, h});
    endtask

    // ----------
    // Sequence
    // ----------
    initial begin
        rst = 1'b1;
        cfg_valid = 1'b0;
        cfg_addr = '0;
        req_seen = '0;
        prev_frame = 1'b1;
        addr_seen = 1'b0;
        for (int i = 0; i < NUM_MASTERS; i++) begin
            start[i] = 1'b0;
            start_addr[i] = '0;
            word_count[i] = '0;
            wr_data[i] = '0;
        end
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        compare({29'h0, pba_if_i.gnt_n}, 32'h7);
        compare({31'h0, owner_valid}, 32'h0);
        launch(0, 32'h0010_0000, 4'h3);
        go();
        burst(0, 0, 32'h0010_0000, 3);
        compare({29'h0, pba_if_i.gnt_n}, 32'h6);
        req_seen = '0;
        launch(0, 32'h0200_0040, 4'hF);
        go();
        burst(0, 0, 32'h0200_0040, 15);
        compare(cur_addr[0], 32'h0200_0078);
        compare({29'h0, req_seen}, 32'h0);
        launch(2, 32'h0800_0000, 4'h0);
        go();
        burst(0, 2, 32'h0800_0000, 1);
        compare({29'h0, req_seen}, 32'h4);
        for (int i = 0; i < NUM_MASTERS; i++) launch(i, 32'h1000 * (i + 1), 4'h1);
        go();
        burst(0, 2, 32'h3000, 1);
        burst(1, 0, 32'h1000, 1);
        burst(2, 1, 32'h2000, 1);
        compare({29'h0, done_seen}, 32'h7);
        launch(0, 32'h0000_0200, 4'h2);
        launch(2, 32'h0810_0100, 4'h2);
        go();
        burst(0, 2, 32'h0810_0100, 2);
        burst(1, 0, 32'h0000_0200, 2);
        compare({30'h0, bus_owner}, 32'h0);
        compare({31'h0, owner_valid}, 32'h1);
        cfg(8'h07, 5'h04, 1'b1, 32'h0010_0528, 1'b1);
        cfg(8'h07, 5'h0B, 1'b1, 32'h0200_0528, 1'b1);
        cfg(8'h07, 5'h0A, 1'b1, 32'h0800_0528, 1'b1);
        cfg(8'h07, 5'h05, 1'b1, 32'h0000_0528, 1'b0);
        cfg(8'h03, 5'h04, 1'b1, 32'h0003_2529, 1'b0);
        cfg(8'h07, 5'h04, 1'b0, 32'h0, 1'b0);
        complete_run();
    end
endmodule
